//--- hw/speed_detector_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 100 MHz aclk, AXI4-Lite word access
// Notes:   Byte address of a register is four times its index
`ifndef SPEED_DETECTOR_CONSTS_SVH
`define SPEED_DETECTOR_CONSTS_SVH

// ----------------------------------------
// Register indexes
// ----------------------------------------
`define IDX_OVS_THRESH  6'h0C
`define IDX_CFG_STATUS  6'h0D
`define IDX_PULSES_UPD  6'h0E
`define IDX_IRQ_STATUS  6'h10
`define IDX_IRQ_MASK    6'h11

// ----------------------------------------
// Configuration and status fields
// ----------------------------------------
`define BIT_CONFIGURED  0
`define BIT_FORCE_ERR   1
`define BIT_OW_FOUND    4
`define BIT_OW_TEST     5
`define BIT_OVS_NOW     10
`define BIT_OVS_SEEN    11
`define BIT_RELAY       12
`define BIT_RCTL0       14
`define BIT_RCTL1       15
`define CFG_WR_MASK     16'hC023

// ----------------------------------------
// Interrupt fields
// ----------------------------------------
`define IRQ_W           3
`define IRQ_OVS         0
`define IRQ_OW          1
`define IRQ_UPD         2

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define REG16_RESET     16'h0000
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS   10
`define SPEED16_WIN_NS  5000000
`define SPEED16_WIN_CYC (`SPEED16_WIN_NS / `CLK_PERIOD_NS)
`define HZ_PER_WIN_CNT  8'hC8

`endif

//--- hw/speed_detector_pkg.sv
// Purpose: Types shared by the speed detector register bank
// Assumes: Constants come from speed_detector_consts.svh
// Notes:   Types only
package speed_detector_pkg;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } rd_state_type;

  typedef logic [15:0] reg16_type;

endpackage

//--- hw/speed_detector_regs.sv
// Purpose: Speed detector register bank with speed measurement
// Assumes: pulse_in and sensor_open synchronous to aclk
// Notes:   AXI4-Lite slave, one read and one write in flight
//
// Functional notes
// - Index 13: write config, read status
// - Bit 0 configures; zero halts measurements
// - Bit 1 force-error flag is only stored, status echoes it
// - Bit 5 enables open-wire test, echoed
// - Status bit 4 shows open wire found
// - Status bit 10 shows current overspeed
// - Bit 11 latches overspeed, read clears
// - Status bit 12 shows relay energized
// - Index 14 holds pulses per 32-bit update
// - Index 12 holds overspeed threshold
// - 16-bit speed refreshes every 5 ms
// - 32-bit speed refreshes per pulse count
`timescale 1ns/1ps
`include "speed_detector_consts.svh"

module speed_detector_regs
#(
  parameter int ADDR_W     = 8,
  parameter int WIN_CYCLES = `SPEED16_WIN_CYC
)
(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [ADDR_W-1:0]            s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [ADDR_W-1:0]            s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         pulse_in,
  input  wire logic                         sensor_open,
  output speed_detector_pkg::reg16_type     speed16,
  output logic [31:0]                       speed32,
  output logic                              relay_energize,
  output logic                              irq
);
  import speed_detector_pkg::*;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  generate
    if (ADDR_W < 8 || WIN_CYCLES < 2)
    begin : g_bad_param
      $error("speed_detector_regs: ADDR_W or WIN_CYCLES too small");
    end
  endgenerate

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic               awready_reg, awready_next;
  logic               wready_reg, wready_next;
  logic               aw_held_reg, aw_held_next;
  logic               w_held_reg, w_held_next;
  logic [5:0]         waddr_reg, waddr_next;
  logic [31:0]        wdata_reg, wdata_next;
  logic [3:0]         wstrb_reg, wstrb_next;
  logic               bvalid_reg, bvalid_next;
  logic [1:0]         bresp_reg, bresp_next;
  rd_state_type       rd_state_reg, rd_state_next;
  logic [31:0]        rdata_reg, rdata_next;
  logic [1:0]         rresp_reg, rresp_next;
  reg16_type          thresh_reg, thresh_next;
  reg16_type          cfg_reg, cfg_next;
  reg16_type          ppu_reg, ppu_next;
  logic [`IRQ_W-1:0]  ist_reg, ist_next;
  logic [`IRQ_W-1:0]  imask_reg, imask_next;
  logic               ovs_seen_reg, ovs_seen_next;
  logic               ovs_now_reg, ovs_now_next;
  logic               ow_reg, ow_next;
  logic               relay_reg, relay_next;
  logic               irq_reg, irq_next;
  logic               pulse_q_reg, pulse_q_next;
  logic [31:0]        win_cnt_reg, win_cnt_next;
  reg16_type          win_pulses_reg, win_pulses_next;
  reg16_type          speed16_reg, speed16_next;
  logic [31:0]        cyc_cnt_reg, cyc_cnt_next;
  reg16_type          upd_pulses_reg, upd_pulses_next;
  logic [31:0]        speed32_reg, speed32_next;

  logic               do_write;
  logic               do_read;
  logic [5:0]         raddr;
  logic               configured;
  logic               pulse_edge;
  logic               ovs_event;
  logic               ow_event;
  logic               upd_event;
  reg16_type          status_word;

  function automatic reg16_type merge16(
    input reg16_type  old_v,
    input logic [31:0] wd,
    input logic [3:0]  ws
  );
    reg16_type res;
    res = old_v;
    if (ws[0])
    begin
      res[7:0] = wd[7:0];
    end
    if (ws[1])
    begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  assign configured = cfg_reg[`BIT_CONFIGURED];
  assign do_write   = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign do_read    = (rd_state_reg == RD_IDLE) & s_axi_arvalid;
  assign raddr      = s_axi_araddr[7:2];

  // ----------------------------------------
  // Measurement datapath
  // ----------------------------------------
  always_comb
  begin
    pulse_q_next    = pulse_in;
    pulse_edge      = pulse_in & ~pulse_q_reg;
    win_cnt_next    = win_cnt_reg;
    win_pulses_next = win_pulses_reg;
    speed16_next    = speed16_reg;
    cyc_cnt_next    = cyc_cnt_reg;
    upd_pulses_next = upd_pulses_reg;
    speed32_next    = speed32_reg;
    upd_event       = 1'b0;
    if (!configured)
    begin
      // Unconfigured stops both measurements; last values stay
      win_cnt_next    = 32'h0000_0000;
      win_pulses_next = `REG16_RESET;
      cyc_cnt_next    = 32'h0000_0000;
      upd_pulses_next = `REG16_RESET;
    end
    else
    begin
      if (win_cnt_reg == 32'(WIN_CYCLES - 1))
      begin
        // Window count times 200 gives Hz for a 5 ms window
        speed16_next    = 16'(win_pulses_reg * `HZ_PER_WIN_CNT);
        win_cnt_next    = 32'h0000_0000;
        win_pulses_next = {15'h0000, pulse_edge};
      end
      else
      begin
        win_cnt_next    = win_cnt_reg + 32'h0000_0001;
        win_pulses_next = win_pulses_reg + {15'h0000, pulse_edge};
      end
      cyc_cnt_next = cyc_cnt_reg + 32'h0000_0001;
      if (pulse_edge)
      begin
        // Zero pulse count means no 32-bit updates at all
        if (ppu_reg != `REG16_RESET &&
            upd_pulses_reg + 16'h0001 >= ppu_reg)
        begin
          speed32_next    = cyc_cnt_reg + 32'h0000_0001;
          cyc_cnt_next    = 32'h0000_0000;
          upd_pulses_next = `REG16_RESET;
          upd_event       = 1'b1;
        end
        else
        begin
          upd_pulses_next = upd_pulses_reg + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // Status and events
  // ----------------------------------------
  always_comb
  begin
    ovs_now_next = configured & (speed16_reg > thresh_reg);
    ow_next      = cfg_reg[`BIT_OW_TEST] & sensor_open;
    relay_next   = ovs_now_reg;
    ovs_event    = ovs_now_next & ~ovs_now_reg;
    ow_event     = ow_next & ~ow_reg;
    status_word  = `REG16_RESET;
    status_word[`BIT_CONFIGURED] = configured;
    status_word[`BIT_FORCE_ERR]  = cfg_reg[`BIT_FORCE_ERR];
    status_word[`BIT_OW_FOUND]   = ow_reg;
    status_word[`BIT_OW_TEST]    = cfg_reg[`BIT_OW_TEST];
    status_word[`BIT_OVS_NOW]    = ovs_now_reg;
    status_word[`BIT_OVS_SEEN]   = ovs_seen_reg;
    status_word[`BIT_RELAY]      = relay_reg;
    status_word[`BIT_RCTL0]      = cfg_reg[`BIT_RCTL0];
    status_word[`BIT_RCTL1]      = cfg_reg[`BIT_RCTL1];
    // A new event wins over the clear of the same read
    ovs_seen_next = (ovs_seen_reg &
                     ~(do_read && raddr == `IDX_CFG_STATUS)) |
                    ovs_now_reg;
    ist_next = ist_reg;
    if (do_read && raddr == `IDX_IRQ_STATUS)
    begin
      ist_next = '0;
    end
    ist_next[`IRQ_OVS] = ist_next[`IRQ_OVS] | ovs_event;
    ist_next[`IRQ_OW]  = ist_next[`IRQ_OW] | ow_event;
    ist_next[`IRQ_UPD] = ist_next[`IRQ_UPD] | upd_event;
    irq_next = |(ist_reg & imask_reg);
  end

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  always_comb
  begin
    aw_held_next = aw_held_reg;
    w_held_next  = w_held_reg;
    waddr_next   = waddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    thresh_next  = thresh_reg;
    cfg_next     = cfg_reg;
    ppu_next     = ppu_reg;
    imask_next   = imask_reg;
    if (s_axi_awvalid && awready_reg)
    begin
      aw_held_next = 1'b1;
      waddr_next   = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && wready_reg)
    begin
      w_held_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (do_write)
    begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = `RESP_OKAY;
      case (waddr_reg)
        `IDX_OVS_THRESH:
          thresh_next = merge16(thresh_reg, wdata_reg, wstrb_reg);
        `IDX_CFG_STATUS:
          // Only defined config bits store; the rest read back as status bits or 0
          cfg_next = merge16(cfg_reg, wdata_reg, wstrb_reg) &
                     `CFG_WR_MASK;
        `IDX_PULSES_UPD:
          ppu_next = merge16(ppu_reg, wdata_reg, wstrb_reg);
        `IDX_IRQ_MASK:
          if (wstrb_reg[0])
          begin
            imask_next = wdata_reg[`IRQ_W-1:0];
          end
        default:
          bresp_next = `RESP_SLVERR;
      endcase
    end
    if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end
    awready_next = ~aw_held_next & ~bvalid_next;
    wready_next  = ~w_held_next & ~bvalid_next;
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  always_comb
  begin
    rd_state_next = rd_state_reg;
    rdata_next    = rdata_reg;
    rresp_next    = rresp_reg;
    case (rd_state_reg)
      RD_IDLE:
        if (s_axi_arvalid)
        begin
          rd_state_next = RD_RESP;
          rresp_next    = `RESP_OKAY;
          rdata_next    = 32'h0000_0000;
          case (raddr)
            `IDX_OVS_THRESH: rdata_next[15:0] = thresh_reg;
            `IDX_CFG_STATUS: rdata_next[15:0] = status_word;
            `IDX_PULSES_UPD: rdata_next[15:0] = ppu_reg;
            `IDX_IRQ_STATUS: rdata_next[`IRQ_W-1:0] = ist_reg;
            `IDX_IRQ_MASK:   rdata_next[`IRQ_W-1:0] = imask_reg;
            default:         rresp_next = `RESP_SLVERR;
          endcase
        end
      RD_RESP:
        if (s_axi_rready)
        begin
          rd_state_next = RD_IDLE;
        end
      default:
        rd_state_next = RD_IDLE;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg    <= 1'b0;
      wready_reg     <= 1'b0;
      aw_held_reg    <= 1'b0;
      w_held_reg     <= 1'b0;
      waddr_reg      <= 6'h00;
      wdata_reg      <= 32'h0000_0000;
      wstrb_reg      <= 4'h0;
      bvalid_reg     <= 1'b0;
      bresp_reg      <= `RESP_OKAY;
      rd_state_reg   <= RD_IDLE;
      rdata_reg      <= 32'h0000_0000;
      rresp_reg      <= `RESP_OKAY;
      thresh_reg     <= `REG16_RESET;
      cfg_reg        <= `REG16_RESET;
      ppu_reg        <= `REG16_RESET;
      ist_reg        <= '0;
      imask_reg      <= '0;
      ovs_seen_reg   <= 1'b0;
      ovs_now_reg    <= 1'b0;
      ow_reg         <= 1'b0;
      relay_reg      <= 1'b0;
      irq_reg        <= 1'b0;
      pulse_q_reg    <= 1'b0;
      win_cnt_reg    <= 32'h0000_0000;
      win_pulses_reg <= `REG16_RESET;
      speed16_reg    <= `REG16_RESET;
      cyc_cnt_reg    <= 32'h0000_0000;
      upd_pulses_reg <= `REG16_RESET;
      speed32_reg    <= 32'h0000_0000;
    end
    else
    begin
      awready_reg    <= awready_next;
      wready_reg     <= wready_next;
      aw_held_reg    <= aw_held_next;
      w_held_reg     <= w_held_next;
      waddr_reg      <= waddr_next;
      wdata_reg      <= wdata_next;
      wstrb_reg      <= wstrb_next;
      bvalid_reg     <= bvalid_next;
      bresp_reg      <= bresp_next;
      rd_state_reg   <= rd_state_next;
      rdata_reg      <= rdata_next;
      rresp_reg      <= rresp_next;
      thresh_reg     <= thresh_next;
      cfg_reg        <= cfg_next;
      ppu_reg        <= ppu_next;
      ist_reg        <= ist_next;
      imask_reg      <= imask_next;
      ovs_seen_reg   <= ovs_seen_next;
      ovs_now_reg    <= ovs_now_next;
      ow_reg         <= ow_next;
      relay_reg      <= relay_next;
      irq_reg        <= irq_next;
      pulse_q_reg    <= pulse_q_next;
      win_cnt_reg    <= win_cnt_next;
      win_pulses_reg <= win_pulses_next;
      speed16_reg    <= speed16_next;
      cyc_cnt_reg    <= cyc_cnt_next;
      upd_pulses_reg <= upd_pulses_next;
      speed32_reg    <= speed32_next;
    end
  end

  assign s_axi_awready  = awready_reg;
  assign s_axi_wready   = wready_reg;
  assign s_axi_bvalid   = bvalid_reg;
  assign s_axi_bresp    = bresp_reg;
  assign s_axi_arready  = (rd_state_reg == RD_IDLE);
  assign s_axi_rvalid   = (rd_state_reg == RD_RESP);
  assign s_axi_rdata    = rdata_reg;
  assign s_axi_rresp    = rresp_reg;
  assign speed16        = speed16_reg;
  assign speed32        = speed32_reg;
  assign relay_energize = relay_reg;
  assign irq            = irq_reg;

endmodule

//--- testbench/speed_detector_regs_assertions.sv
// Purpose: Bus handshake and output timing checks for the register bank
// Assumes: One aclk domain, aresetn synchronous and active low
// Notes:   Bound from the bench top, watches ports only
`timescale 1ns/1ps
module speed_detector_regs_assertions
#(
  parameter int WIN_CYCLES = 100
)
(
  input wire logic                          aclk,
  input wire logic                          aresetn,
  input wire logic                          s_axi_awvalid,
  input wire logic                          s_axi_awready,
  input wire logic                          s_axi_wvalid,
  input wire logic                          s_axi_wready,
  input wire logic [1:0]                    s_axi_bresp,
  input wire logic                          s_axi_bvalid,
  input wire logic                          s_axi_bready,
  input wire logic                          s_axi_arvalid,
  input wire logic                          s_axi_arready,
  input wire logic [31:0]                   s_axi_rdata,
  input wire logic [1:0]                    s_axi_rresp,
  input wire logic                          s_axi_rvalid,
  input wire logic                          s_axi_rready,
  input wire logic                          pulse_in,
  input wire speed_detector_pkg::reg16_type speed16,
  input wire logic [31:0]                   speed32,
  input wire logic                          relay_energize
);
  import speed_detector_pkg::*;

  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  // Saturating, so a long idle stretch cannot wrap into a false pass
  logic        pulse_q;
  logic [31:0] since_rise;
  logic [31:0] since_s16;

  always_ff @(posedge aclk)
  begin
    pulse_q <= pulse_in;
    if (!aresetn || (pulse_in && !pulse_q))
      since_rise <= (aresetn) ? 32'h0 : 32'hFFFF;
    else if (since_rise != 32'hFFFFFFFF)
      since_rise <= since_rise + 32'h1;
    if (!aresetn || (speed16 != $past(speed16)))
      since_s16 <= 32'h0;
    else if (since_s16 != 32'hFFFFFFFF)
      since_s16 <= since_s16 + 32'h1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read not answered next cycle");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed before taken");
  a_read_refuse: assert property (s_axi_rvalid |->
    !s_axi_arready) else $error("address accepted during read answer");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered in time");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer changed before taken");
  a_write_refuse: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write accepted during write answer");
  a_relay_speed: assert property (relay_energize |->
    speed16 != 16'h0000) else $error("relay energized at zero speed");
  a_speed32_pulse: assert property ($changed(speed32) |->
    since_rise <= 32'h3) else $error("speed32 moved without a pulse");
  a_speed16_window: assert property ($changed(speed16) |->
    since_s16 >= 32'(WIN_CYCLES - 1))
    else $error("speed16 refreshed early");
endmodule

//--- testbench/speed_sensor_model.sv
// Purpose: Speed sensor front end driving pulses and open-wire sense
// Assumes: Square wave with a programmable half period in aclk cycles
// Notes:   Half period zero holds the line low, as a stopped wheel does
`timescale 1ns/1ps
module speed_sensor_model
(
  input wire logic       aclk,
  input wire logic [7:0] half_period,
  input wire logic       open_req,
  output logic           pulse_in,
  output logic           sensor_open
);
  logic [7:0] cnt;

  initial
  begin
    pulse_in = 1'b0;
    cnt = 8'h00;
  end

  always @(posedge aclk)
  begin
    if (half_period == 8'h00)
    begin
      pulse_in <= 1'b0;
      cnt <= 8'h00;
    end
    else if (cnt + 8'h01 >= half_period)
    begin
      cnt <= 8'h00;
      pulse_in <= ~pulse_in;
    end
    else
      cnt <= cnt + 8'h01;
  end

  assign sensor_open = open_req;
endmodule

//--- testbench/test_speed_detector_regs.sv
// Purpose: Register, measurement and interrupt tests of the bank
// Assumes: Window shortened to 100 cycles, speed16 is count times 200
// Notes:   Bus tasks hold each channel until its own handshake
`timescale 1ns/1ps
`include "speed_detector_consts.svh"
module test_speed_detector_regs;
  import speed_detector_pkg::*;
  localparam int         WIN   = 100;
  localparam logic [7:0] A_OVS = {`IDX_OVS_THRESH, 2'b00};
  localparam logic [7:0] A_CFG = {`IDX_CFG_STATUS, 2'b00};
  localparam logic [7:0] A_PPU = {`IDX_PULSES_UPD, 2'b00};
  localparam logic [7:0] A_IRQ = {`IDX_IRQ_STATUS, 2'b00};
  localparam logic [7:0] A_MSK = {`IDX_IRQ_MASK, 2'b00};
  localparam logic [7:0] A_BAD = 8'h3C;
  localparam logic [1:0] OK    = `RESP_OKAY;
  localparam logic [1:0] ERR   = `RESP_SLVERR;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, pulse_in;
  logic        sensor_open, relay_energize, irq, open_req;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, half_p;
  logic [31:0] s_axi_wdata, s_axi_rdata, speed32;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  reg16_type   speed16;
  int          n_fail, n_tests, cycles;

  speed_detector_regs #(.ADDR_W(8), .WIN_CYCLES(WIN)) i_speed_detector_regs
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pulse_in(pulse_in), .sensor_open(sensor_open), .speed16(speed16),
    .speed32(speed32), .relay_energize(relay_energize), .irq(irq)
  );

  speed_sensor_model i_speed_sensor_model
  (
    .aclk(aclk), .half_period(half_p), .open_req(open_req),
    .pulse_in(pulse_in), .sensor_open(sensor_open)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic done;
    done = 1'b0;
    // Let an edge pass so bready is not lowered and raised in one step
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
        check({30'h0, s_axi_bresp}, {30'h0, r});
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        done = 1'b1;
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, e);
        check({30'h0, s_axi_rresp}, {30'h0, r});
      end
    end
  endtask

  task automatic test_done();
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Whole run is under 800 cycles, so this only trips on a hang
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_fail++;
      test_done();
    end
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, open_req} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, half_p} = 24'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A_OVS, 32'h0, OK);
    rd(A_CFG, 32'h0, OK);
    rd(A_PPU, 32'h0, OK);
    rd(A_MSK, 32'h0, OK);
    wr(A_OVS, 32'h03E8, OK);
    rd(A_OVS, 32'h03E8, OK);
    // Five pulses is one turn of a five-tooth wheel
    wr(A_PPU, 32'h0005, OK);
    rd(A_PPU, 32'h0005, OK);
    wr(A_BAD, 32'h1234, ERR);
    rd(A_BAD, 32'h0, ERR);
    wr(A_MSK, 32'h2, OK);
    open_req <= 1'b1;
    wr(A_CFG, 32'h0020, OK);
    repeat (4) @(posedge aclk);
    rd(A_CFG, 32'h0030, OK);
    check({31'h0, irq}, 32'h1);
    rd(A_IRQ, 32'h2, OK);
    repeat (3) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    open_req <= 1'b0;
    half_p <= 8'd5;
    wr(A_CFG, 32'h0023, OK);
    repeat (350) @(posedge aclk);
    check({16'h0, speed16}, (WIN / 10) * `HZ_PER_WIN_CNT);
    check(speed32, 32'd50);
    check({31'h0, relay_energize}, 32'h1);
    rd(A_CFG, 32'h1C23, OK);
    wr(A_OVS, 32'hFFFF, OK);
    repeat (4) @(posedge aclk);
    rd(A_CFG, 32'h0823, OK);
    rd(A_CFG, 32'h0023, OK);
    check({31'h0, relay_energize}, 32'h0);
    wr(A_CFG, 32'h0000, OK);
    half_p <= 8'd3;
    repeat (300) @(posedge aclk);
    check({16'h0, speed16}, (WIN / 10) * `HZ_PER_WIN_CNT);
    check(speed32, 32'd50);
    rd(A_CFG, 32'h0000, OK);
    check({31'h0, irq}, 32'h0);
    rd(A_IRQ, 32'h5, OK);
    test_done();
  end
endmodule

bind speed_detector_regs speed_detector_regs_assertions
  #(.WIN_CYCLES(WIN_CYCLES)) i_speed_detector_regs_assertions
(
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pulse_in(pulse_in), .speed16(speed16), .speed32(speed32),
  .relay_energize(relay_energize)
);
